// >>> cis_pkg.sv
// Purpose: Shared constants and types for the interrupt sequencer.
// Assumes: One core clock at 200 MHz, AXI4-Lite register access.
// Notes:   Offsets are byte addresses, one 32-bit word per register.
package cis_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 5;

	// Sequence lengths in core clock cycles
	localparam int RESP_CYCLES       = 4;
	localparam int JMP_CYCLES        = 3;
	localparam int RET_CYCLES        = 4;
	localparam int WAKE_EXTRA_CYCLES = 4;

	// Return address size in bytes on the stack
	localparam logic [15:0] RET_ADDR_BYTES = 16'h0002;

	// Reset values
	localparam logic [15:0] SP_RESET  = 16'h00ff;
	localparam logic        GIE_RESET = 1'b0;
	localparam logic [7:0]  EN_RESET  = 8'h00;

	// Bus address width and register byte offsets
	localparam int          AXI_AW      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_ENABLE = 8'h04;
	localparam logic [7:0]  ADDR_FLAGS  = 8'h08;
	localparam logic [7:0]  ADDR_STATUS = 8'h0c;
	localparam logic [7:0]  ADDR_SP     = 8'h10;

	// Field positions
	localparam int CTRL_GIE_BIT    = 0;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_RET_BIT    = 1;
	localparam int STAT_WAKE_BIT   = 2;
	localparam int STAT_SLEEP_BIT  = 3;
	localparam int STAT_VEC_LSB    = 8;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ALU operations
	localparam logic [1:0] ALU_ADD = 2'h0;
	localparam logic [1:0] ALU_SUB = 2'h1;
	localparam logic [1:0] ALU_AND = 2'h2;
	localparam logic [1:0] ALU_OR  = 2'h3;

	typedef enum logic [2:0] {st_run, st_wake, st_resp, st_jmp, st_ret} cis_state_type;

endpackage

// >>> cis_sequencer.sv
// Purpose: Interrupt acceptance and sequencing for an 8-bit core.
// Assumes: Peripherals and core control run on clk; NUM_SRC <= 8.
// Notes:   Vector 0 is reset; source n owns vector n+1.
`timescale 1ns/1ps
module cis_sequencer #(
	parameter int                 NUM_SRC              = 8,
	parameter logic [NUM_SRC-1:0] LEVEL_MASK           = NUM_SRC'(1),
	parameter logic [15:0]        SP_INIT              = cis_pkg::SP_RESET,
	parameter int                 SLEEP_STARTUP_CYCLES = 6
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic [cis_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [cis_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [NUM_SRC-1:0]        src_event,
	input  wire logic                      instr_done,
	input  wire logic                      enable_instr,
	input  wire logic                      disable_instr,
	input  wire logic                      interrupt_return_instr,
	input  wire logic                      core_sleep,
	input  wire logic [7:0]                alu_a,
	input  wire logic [7:0]                alu_b,
	input  wire logic [1:0]                alu_op,
	output logic [7:0]                     alu_result,
	output logic                           core_hold,
	output logic                           pc_push,
	output logic                           pc_pop,
	output logic                           handler_go,
	output logic [3:0]                     vec_index,
	output logic [15:0]                    stack_ptr,
	output logic                           global_enable,
	output logic                           waking
);
	import cis_pkg::*;

	// Lowest set index wins: the vector table order is the priority order
	function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Byte lane merge for partial writes
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		lane_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	cis_state_type      state_r, state_nxt;
	logic [15:0]        cnt_r, cnt_nxt;
	logic [NUM_SRC-1:0] flag_r, flag_nxt;
	logic [NUM_SRC-1:0] en_r, en_nxt;
	logic               gie_r, gie_nxt;
	logic [15:0]        sp_r, sp_nxt;
	logic [3:0]         vec_r, vec_nxt;

	// Bus slave state
	logic               aw_full_r, w_full_r;
	logic [AXI_AW-1:0]  aw_addr_r;
	logic [31:0]        w_data_r;
	logic [3:0]         w_strb_r;
	logic               aw_rdy_r, w_rdy_r, bvalid_r, ar_rdy_r, rvalid_r;
	logic [1:0]         bresp_r, rresp_r;
	logic [31:0]        rdata_r;
	logic [7:0]         alu_r;
	logic               hold_r, push_r, pop_r, go_r, wake_r;

	// Write channel decode
	wire aw_fire     = s_axi_awvalid & aw_rdy_r;
	wire w_fire      = s_axi_wvalid & w_rdy_r;
	wire do_write    = aw_full_r & w_full_r & ~bvalid_r;
	wire aw_full_nxt = do_write ? 1'b0 : (aw_full_r | aw_fire);
	wire w_full_nxt  = do_write ? 1'b0 : (w_full_r | w_fire);
	wire wr_ctrl     = do_write & (aw_addr_r == ADDR_CTRL) & w_strb_r[0];
	wire wr_en       = do_write & (aw_addr_r == ADDR_ENABLE) & w_strb_r[0];
	wire wr_flags    = do_write & (aw_addr_r == ADDR_FLAGS) & w_strb_r[0];
	wire wr_sp       = do_write & (aw_addr_r == ADDR_SP);
	wire wr_mapped   = (aw_addr_r == ADDR_CTRL) | (aw_addr_r == ADDR_ENABLE) |
		(aw_addr_r == ADDR_FLAGS) | (aw_addr_r == ADDR_STATUS) | (aw_addr_r == ADDR_SP);
	wire [NUM_SRC-1:0] w1c_mask = wr_flags ? w_data_r[NUM_SRC-1:0] : '0;

	// Request evaluation
	// latched flag requests and live level requests
	wire [NUM_SRC-1:0] pend = (flag_r & ~LEVEL_MASK) | (src_event & LEVEL_MASK);
	wire [NUM_SRC-1:0] req  = pend & en_r;
	wire               any_req = |req;
	wire [3:0]         sel  = first_set(req);
	wire               cnt_zero = (cnt_r == 16'h0000);

	wire take = instr_done & gie_r & ~disable_instr & ~enable_instr & any_req & ~core_sleep;
	wire wake_req = core_sleep & gie_r & ~disable_instr & any_req;
	wire wake_take = (state_r == st_wake) & cnt_zero & gie_r & any_req;
	wire accept = ((state_r == st_run) & ~interrupt_return_instr & take) | wake_take;
	wire ret_end = (state_r == st_ret) & cnt_zero;
	wire jmp_end = (state_r == st_jmp) & cnt_zero;

	wire [NUM_SRC-1:0] hw_clr = accept ? (NUM_SRC'(1) << sel) & ~LEVEL_MASK : '0;

	// Flag update
	// set even when disabled
	// flags wait for enable
	// Set wins over both clears so a coincident event is kept
	assign flag_nxt = ((flag_r & ~w1c_mask & ~hw_clr) | src_event) & ~LEVEL_MASK;

	assign en_nxt = wr_en ? w_data_r[NUM_SRC-1:0] : en_r;

	// Global enable update; accept and disable coincide only at wake entry, both clear it
	always_comb begin
		gie_nxt = gie_r;
		if (accept) begin
			gie_nxt = 1'b0;
		end else if (disable_instr) begin
			gie_nxt = 1'b0;
		end else if (ret_end | enable_instr) begin
			gie_nxt = 1'b1;
		end else if (wr_ctrl) begin
			gie_nxt = w_data_r[CTRL_GIE_BIT];
		end
	end

	// Stack pointer: software may move it only while no sequence runs
	always_comb begin
		sp_nxt = sp_r;
		if (accept) begin
			sp_nxt = sp_r - RET_ADDR_BYTES;
		end else if (ret_end) begin
			sp_nxt = sp_r + RET_ADDR_BYTES;
		end else if (wr_sp & (state_r == st_run)) begin
			sp_nxt = lane_merge(sp_r, w_data_r[15:0], w_strb_r[1:0]);
		end
	end

	assign vec_nxt = accept ? 4'(sel + 4'h1) : vec_r;

	// Sequencer; the status word is left alone here
	// no status save
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_zero ? cnt_r : 16'(cnt_r - 16'h0001);
		unique case (state_r)
			st_run: begin
				if (interrupt_return_instr) begin
					state_nxt = st_ret;
					cnt_nxt   = 16'(RET_CYCLES - 1);
				end else if (take) begin
					state_nxt = st_resp;
					cnt_nxt   = 16'(RESP_CYCLES - 1);
				end else if (wake_req) begin
					state_nxt = st_wake;
					cnt_nxt   = 16'(SLEEP_STARTUP_CYCLES + WAKE_EXTRA_CYCLES - 1);
				end
			end
			st_wake: begin
				if (cnt_zero) begin
					state_nxt = wake_take ? st_resp : st_run;
					cnt_nxt   = 16'(RESP_CYCLES - 1);
				end
			end
			st_resp: begin
				if (cnt_zero) begin
					state_nxt = st_jmp;
					cnt_nxt   = 16'(JMP_CYCLES - 1);
				end
			end
			st_jmp: begin
				if (cnt_zero) begin
					state_nxt = st_run;
				end
			end
			st_ret: begin
				// back to run, next boundary is after one instruction
				if (cnt_zero) begin
					state_nxt = st_run;
				end
			end
		endcase
	end

	wire [7:0] alu_val = (alu_op == ALU_ADD) ? 8'(alu_a + alu_b) :
		(alu_op == ALU_SUB) ? 8'(alu_a - alu_b) :
		(alu_op == ALU_AND) ? (alu_a & alu_b) : (alu_a | alu_b);

	// Read decode
	wire [31:0] stat_word = 32'({vec_r, 4'h0, core_sleep, state_r == st_wake,
		state_r == st_ret, state_r != st_run});
	wire ar_fire = s_axi_arvalid & ar_rdy_r;
	wire rd_map  = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_ENABLE) |
		(s_axi_araddr == ADDR_FLAGS) | (s_axi_araddr == ADDR_STATUS) | (s_axi_araddr == ADDR_SP);
	wire [31:0] rd_val = (s_axi_araddr == ADDR_CTRL)   ? 32'(gie_r) :
		(s_axi_araddr == ADDR_ENABLE) ? 32'(en_r) :
		(s_axi_araddr == ADDR_FLAGS)  ? 32'(pend) :
		(s_axi_araddr == ADDR_STATUS) ? stat_word :
		(s_axi_araddr == ADDR_SP)     ? 32'(sp_r) : 32'h0000_0000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= st_run;
			cnt_r   <= 16'h0000;
			flag_r  <= '0;
			en_r    <= NUM_SRC'(EN_RESET);
			gie_r   <= GIE_RESET;
			sp_r    <= SP_INIT;
			vec_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			flag_r  <= flag_nxt;
			en_r    <= en_nxt;
			gie_r   <= gie_nxt;
			sp_r    <= sp_nxt;
			vec_r   <= vec_nxt;
		end
	end

	// Core-facing strobes, all registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_r <= 1'b0;
			push_r <= 1'b0;
			pop_r  <= 1'b0;
			go_r   <= 1'b0;
			wake_r <= 1'b0;
			alu_r  <= 8'h00;
		end else begin
			hold_r <= (state_nxt != st_run);
			push_r <= accept;
			pop_r  <= ret_end;
			go_r   <= jmp_end;
			wake_r <= (state_nxt == st_wake);
			alu_r  <= alu_val;
		end
	end

	// Write address and data taken in either order
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			aw_rdy_r  <= 1'b1;
			w_rdy_r   <= 1'b1;
			aw_addr_r <= '0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			aw_rdy_r  <= ~aw_full_nxt;
			w_rdy_r   <= ~w_full_nxt;
			if (aw_fire) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
		end
	end

	// Write response holds until taken; unmapped answers SLVERR
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read: one outstanding, address refused while data waits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (ar_fire) begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r  <= rd_val;
			rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r & s_axi_rready) begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// Output wiring
	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready  = w_rdy_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign alu_result    = alu_r;
	assign core_hold     = hold_r;
	assign pc_push       = push_r;
	assign pc_pop        = pop_r;
	assign handler_go    = go_r;
	assign vec_index     = vec_r;
	assign stack_ptr     = sp_r;
	assign global_enable = gie_r;
	assign waking        = wake_r;

endmodule // cis_sequencer

// >>> cis_monitor.sv
// Purpose: Port timing checks for the interrupt sequencer.
// Assumes: One clock domain, reset async active high.
// Notes:   Bound from tb_top; sees design ports only.
`timescale 1ns/1ps
module cis_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        enable_instr,
	input wire logic        disable_instr,
	input wire logic        interrupt_return_instr,
	input wire logic [7:0]  alu_a,
	input wire logic [7:0]  alu_b,
	input wire logic [1:0]  alu_op,
	input wire logic [7:0]  alu_result,
	input wire logic        core_hold,
	input wire logic        pc_push,
	input wire logic        pc_pop,
	input wire logic        handler_go,
	input wire logic [15:0] stack_ptr,
	input wire logic        global_enable
);
	import cis_pkg::*;

	// All checks share the core clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_PUSH_SP: assert property (pc_push |-> stack_ptr == $past(stack_ptr) - RET_ADDR_BYTES)
		else $error("stack pointer not lowered by two on entry");
	AST_PUSH_MASK: assert property (pc_push |-> !global_enable)
		else $error("global enable still set on entry");
	AST_GATE: assert property (!global_enable |=> !pc_push)
		else $error("entry taken with global enable clear");
	AST_RESP_HOLD: assert property ($rose(pc_push) |-> core_hold [*4])
		else $error("core released before four response cycles");
	AST_HANDLER: assert property ($rose(pc_push) |-> ##[6:8] handler_go)
		else $error("handler start not seen after response and jump");
	AST_DISABLE: assert property (disable_instr |=> !pc_push && !global_enable)
		else $error("entry or enable after disable instruction");
	AST_ENABLE: assert property (enable_instr && !core_hold |=> !pc_push && global_enable)
		else $error("entry right after enable instruction");
	AST_RET_LEN: assert property (interrupt_return_instr && !core_hold |-> ##[3:5] pc_pop)
		else $error("return did not end in four cycles");
	AST_RET_END: assert property (pc_pop |-> global_enable && stack_ptr == $past(stack_ptr) + RET_ADDR_BYTES)
		else $error("return left enable or stack pointer wrong");
	AST_ALU_ADD: assert property ($past(alu_op) == ALU_ADD |-> alu_result == 8'($past(alu_a) + $past(alu_b)))
		else $error("sum not written one cycle later");
endmodule // cis_monitor

// >>> cis_periph_model.sv
// Purpose: Peripheral side raising interrupt requests.
// Assumes: Flag sources pulse one cycle, level sources hold.
// Notes:   Bench asks through fire (pulse) and cond (level).
`timescale 1ns/1ps
module cis_periph_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] fire,
	input  wire logic [7:0] cond,
	output logic [7:0]      src_event
);
	// Registered so requests never change on the sampling edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			src_event <= 8'h00;
		end else begin
			src_event <= fire | cond;
		end
	end
endmodule // cis_periph_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the interrupt sequencer.
// Assumes: Sleep start-up set to zero; source 0 level-type.
// Notes:   Table rows cover priority, later cases by hand.
`timescale 1ns/1ps
module tb_top;
	import cis_pkg::*;
	typedef struct packed {logic [7:0] en; logic [7:0] f; logic [3:0] v;} cis_row_type;
	logic        clk = 1'b0, reset = 1'b1, instr_done = 1'b0, enable_instr = 1'b0, disable_instr = 1'b0;
	logic        interrupt_return_instr = 1'b0, core_sleep = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        core_hold, pc_push, pc_pop, handler_go, global_enable, waking;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fire = 8'h00, cond = 8'h00;
	logic [7:0]  alu_a = 8'h00, alu_b = 8'h00, alu_result, src_event, e;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hf, vec_index;
	logic [1:0]  s_axi_bresp, s_axi_rresp, alu_op = 2'h0, rs;
	logic [15:0] stack_ptr;
	int          miscompares = 0, comparisons = 0, n;
	cis_row_type rows [4] = '{'{8'h02, 8'h02, 4'h2}, '{8'h06, 8'h06, 4'h2}, '{8'h04, 8'h06, 4'h3},
		'{8'h80, 8'h80, 4'h8}};

	// Clock, 5 ns period
	always #2.5 clk = ~clk;

	cis_sequencer #(.NUM_SRC(8), .LEVEL_MASK(8'h01), .SLEEP_STARTUP_CYCLES(0)) i_cis_sequencer (
		.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.src_event(src_event), .instr_done(instr_done), .enable_instr(enable_instr),
		.disable_instr(disable_instr), .interrupt_return_instr(interrupt_return_instr),
		.core_sleep(core_sleep), .alu_a(alu_a), .alu_b(alu_b), .alu_op(alu_op), .alu_result(alu_result),
		.core_hold(core_hold), .pc_push(pc_push), .pc_pop(pc_pop), .handler_go(handler_go),
		.vec_index(vec_index), .stack_ptr(stack_ptr), .global_enable(global_enable), .waking(waking));
	cis_periph_model i_cis_periph_model (.clk(clk), .reset(reset), .fire(fire), .cond(cond), .src_event(src_event));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Bus write; handshakes judged at negedge, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdr(input logic [7:0] a);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// One instruction boundary, optionally with disable or enable
	task automatic step(input logic dis, input logic ena);
		@(posedge clk);
		instr_done <= 1'b1;
		disable_instr <= dis;
		enable_instr <= ena;
		@(posedge clk);
		instr_done <= 1'b0;
		disable_instr <= 1'b0;
		enable_instr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic pulse(input logic [7:0] f);
		fire <= f;
		@(posedge clk);
		fire <= 8'h00;
		repeat (3) @(posedge clk);
	endtask

	// Full entry, jump, handler start and return
	task automatic serve(input logic [3:0] v, input logic woke);
		if (!woke) begin
			step(1'b0, 1'b0);
		end
		check(pc_push, 1'b1);
		check(vec_index, v);
		check(stack_ptr, SP_RESET - RET_ADDR_BYTES);
		check(global_enable, 1'b0);
		for (n = 0; handler_go !== 1'b1 && n < 20; n++) @(negedge clk);
		check(handler_go, 1'b1);
		check(n, RESP_CYCLES + JMP_CYCLES);
		@(posedge clk);
		interrupt_return_instr <= 1'b1;
		@(posedge clk);
		interrupt_return_instr <= 1'b0;
		for (n = 0; pc_pop !== 1'b1 && n < 20; n++) @(negedge clk);
		check(stack_ptr, SP_RESET);
		check(global_enable, 1'b1);
		@(posedge clk);
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#100us;
		miscompares++;
		results();
	end

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			wr(ADDR_FLAGS, 32'hff);
			wr(ADDR_ENABLE, {24'h0, rows[i].en});
			pulse(rows[i].f);
			wr(ADDR_CTRL, 32'h1);
			serve(rows[i].v, 1'b0);
			rdr(ADDR_FLAGS);
			check(rd, {24'h0, rows[i].f & ~(8'h01 << (rows[i].v - 4'h1))});
			$display("row %0d done", i);
		end
		// Disable with a request in the same cycle, then enable
		wr(ADDR_FLAGS, 32'hff);
		wr(ADDR_ENABLE, 32'h02);
		pulse(8'h02);
		wr(ADDR_CTRL, 32'h1);
		step(1'b1, 1'b0);
		check(pc_push, 1'b0);
		check(global_enable, 1'b0);
		step(1'b0, 1'b1);
		check(pc_push, 1'b0);
		check(global_enable, 1'b1);
		serve(4'h2, 1'b0);
		$display("disable and enable done");
		// Clear by writing one, level source that vanished
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_ENABLE, 32'h01);
		pulse(8'h02);
		wr(ADDR_FLAGS, 32'h0);
		rdr(ADDR_FLAGS);
		check(rd, 32'h02);
		wr(ADDR_FLAGS, 32'h02);
		rdr(ADDR_FLAGS);
		check(rd, 32'h0);
		cond <= 8'h01;
		repeat (3) @(posedge clk);
		cond <= 8'h00;
		repeat (3) @(posedge clk);
		wr(ADDR_CTRL, 32'h1);
		step(1'b0, 1'b0);
		check(pc_push, 1'b0);
		$display("flag clear and level done");
		// Level request served while it persists
		@(posedge clk);
		cond <= 8'h01;
		repeat (2) @(posedge clk);
		serve(4'h1, 1'b0);
		cond <= 8'h00;
		// Wake from sleep: four extra cycles before entry
		wr(ADDR_ENABLE, 32'h02);
		core_sleep <= 1'b1;
		fire <= 8'h02;
		@(posedge clk);
		fire <= 8'h00;
		for (n = 0; waking !== 1'b1 && n < 20; n++) @(negedge clk);
		for (n = 0; waking === 1'b1 && n < 20; n++) @(negedge clk);
		check(n, WAKE_EXTRA_CYCLES);
		serve(4'h2, 1'b1);
		core_sleep <= 1'b0;
		$display("level and wake done");
		// Unmapped place answers with an error
		rdr(8'h20);
		check(rs, RESP_SLVERR);
		wr(8'h24, 32'h1);
		check(rs, RESP_SLVERR);
		$display("unmapped done");
		// All four operations, result one cycle later
		for (int op = 0; op < 4; op++) begin
			alu_a <= 8'h9c;
			alu_b <= 8'h35;
			alu_op <= op[1:0];
			@(posedge clk);
			@(negedge clk);
			e = op == 0 ? 8'hd1 : op == 1 ? 8'h67 : op == 2 ? 8'h14 : 8'hbd;
			check(alu_result, e);
			@(posedge clk);
		end
		$display("alu done");
		// Second reset in mid-run
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check({vec_index, stack_ptr, global_enable, core_hold, waking}, {4'h0, SP_RESET, 1'b0, 1'b0, 1'b0});
		$display("reset done");
		results();
	end
endmodule // tb_top

bind cis_sequencer cis_monitor i_cis_monitor (.clk(clk), .reset(reset), .enable_instr(enable_instr),
	.disable_instr(disable_instr), .interrupt_return_instr(interrupt_return_instr), .alu_a(alu_a),
	.alu_b(alu_b), .alu_op(alu_op), .alu_result(alu_result), .core_hold(core_hold), .pc_push(pc_push),
	.pc_pop(pc_pop), .handler_go(handler_go), .stack_ptr(stack_ptr), .global_enable(global_enable));
